// ==== hdl/rgd_pkg.sv ====
// constants and types shared by the led command decoder
package rgd_pkg;
  localparam int          CMD_W             = 8;
  localparam int          VAL_W             = 5;
  localparam logic [7:0]  ADDR_BYTE         = 8'h70;
  localparam logic [2:0]  FN_SHUTDOWN       = 3'h0;
  localparam logic [2:0]  FN_PEAK_STEP      = 3'h1;
  localparam logic [2:0]  FN_DUTY_ONE       = 3'h2;
  localparam logic [2:0]  FN_DUTY_TWO       = 3'h3;
  localparam logic [2:0]  FN_DUTY_THREE     = 3'h4;
  localparam logic [2:0]  FN_RISE_TARGET    = 3'h5;
  localparam logic [2:0]  FN_FALL_TARGET    = 3'h6;
  localparam logic [2:0]  FN_STEP_TIME_RUN  = 3'h7;
  localparam logic [4:0]  STEP_MAX          = 5'h1F;
  localparam logic [4:0]  RST_STEP          = 5'h00;
  localparam logic [4:0]  RST_DUTY          = 5'h00;
  localparam logic [4:0]  RST_TARGET        = 5'h00;
  localparam logic [4:0]  RST_STEP_TIME     = 5'h00;
  localparam logic [3:0]  BYTE_BITS         = 4'h8;
  localparam int          CLK_HZ            = 100_000_000;
  localparam int          STEP_LSB_MS       = 8;
  localparam int          STEP_LSB_CYCLES   = STEP_LSB_MS * (CLK_HZ / 1000);
  localparam int          PWM_FREQ_HZ       = 2100;
  localparam logic [4:0]  PWM_LAST          = 5'h1E;
  localparam int          PWM_TICK_CYCLES   = CLK_HZ / (PWM_FREQ_HZ * 31);
  localparam logic [10:0] PWM_TICK_LAST     = 11'(PWM_TICK_CYCLES - 1);
  localparam int          CHANNELS          = 3;

  typedef enum logic [2:0] {
    RX_IDLE, RX_ADDR, RX_ACK_ADDR, RX_DATA, RX_ACK_DATA, RX_IGNORE
  } rgd_rx_state_t;
endpackage

// ==== hdl/rgd_i2c_rx.sv ====
// serial bus target front end on the link clock, posts command bytes by toggle
`timescale 1ns/1ps
module rgd_i2c_rx (
  input  wire logic       link_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_tgl_o
);
  logic [2:0]                   scl_reg,   scl_next;
  logic [2:0]                   sda_reg,   sda_next;
  rgd_pkg::rgd_rx_state_t       state_reg, state_next;
  logic [7:0]                   shift_reg, shift_next;
  logic [3:0]                   cnt_reg,   cnt_next;
  logic                         ack_reg,   ack_next;
  logic [7:0]                   cmd_reg,   cmd_next;
  logic                         tgl_reg,   tgl_next;
  logic                         scl_rise, scl_fall, start_seen, stop_seen;

  // bit 0 is the first sync stage, bit 2 the delayed copy
  assign scl_rise   = scl_reg[1] & ~scl_reg[2];
  assign scl_fall   = ~scl_reg[1] & scl_reg[2];
  assign start_seen = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
  assign stop_seen  = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];

  always_comb begin
    scl_next   = {scl_reg[1:0], scl_i};
    sda_next   = {sda_reg[1:0], sda_i};
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    ack_next   = ack_reg;
    cmd_next   = cmd_reg;
    tgl_next   = tgl_reg;
    if (start_seen) begin
      state_next = rgd_pkg::RX_ADDR;
      cnt_next   = 4'h0;
      ack_next   = 1'b0;
    end else if (stop_seen) begin
      state_next = rgd_pkg::RX_IDLE;
      ack_next   = 1'b0;
    end else begin
      case (state_reg)
        rgd_pkg::RX_ADDR, rgd_pkg::RX_DATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_reg[1]};
            cnt_next   = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == rgd_pkg::BYTE_BITS) begin
            cnt_next = 4'h0;
            if (state_reg == rgd_pkg::RX_ADDR) begin
              if (shift_reg == rgd_pkg::ADDR_BYTE) begin
                state_next = rgd_pkg::RX_ACK_ADDR;
                ack_next   = 1'b1;
              end else begin
                state_next = rgd_pkg::RX_IGNORE;
              end
            end else begin
              state_next = rgd_pkg::RX_ACK_DATA;
              ack_next   = 1'b1;
              cmd_next   = shift_reg;
              tgl_next   = ~tgl_reg;
            end
          end
        end
        rgd_pkg::RX_ACK_ADDR: begin
          if (scl_fall) begin
            ack_next   = 1'b0;
            state_next = rgd_pkg::RX_DATA;
          end
        end
        rgd_pkg::RX_ACK_DATA: begin
          if (scl_fall) begin
            ack_next   = 1'b0;
            state_next = rgd_pkg::RX_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_reg   <= 3'h7;
      sda_reg   <= 3'h7;
      state_reg <= rgd_pkg::RX_IDLE;
      shift_reg <= 8'h00;
      cnt_reg   <= 4'h0;
      ack_reg   <= 1'b0;
      cmd_reg   <= 8'h00;
      tgl_reg   <= 1'b0;
    end else begin
      scl_reg   <= scl_next;
      sda_reg   <= sda_next;
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      ack_reg   <= ack_next;
      cmd_reg   <= cmd_next;
      tgl_reg   <= tgl_next;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~ack_reg;
  assign cmd_byte_o = cmd_reg;
  assign cmd_tgl_o  = tgl_reg;
endmodule

// ==== hdl/rgd_pwm_chan.sv ====
// one duty modulator channel with registered output
`timescale 1ns/1ps
module rgd_pwm_chan #(
  parameter int W = 5
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] duty_i,
  input  wire logic         gate_i,
  output logic              pwm_o
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic         out_reg, out_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (tick_i) begin
      cnt_next = (cnt_reg == W'(rgd_pkg::PWM_LAST)) ? '0 : W'(cnt_reg + 1'b1);
    end
    // duty 0 never on, all ones always on since count tops out one below
    out_next = gate_i && (cnt_reg < duty_i);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign pwm_o = out_reg;
endmodule

// ==== hdl/rgd_led_ctrl.sv ====
// three channel led command decoder: bus front end, registers, dimming, pwm
//
// Overview of operation
// - a frame carries exactly an address byte then one command byte
// - answer only to address byte 0111 0000 (7-bit 011 1000, write)
// - command bits 7..5 select the function, bits 4..0 carry its value
// - function 000 forces all led currents off, value ignored
// - function 001 stores value as binary peak current step
// - peak step applies to all channels at once, without dimming
// - each channel keeps its own 5-bit duty, 32 levels
// - peak step is common; each channel's duty sets its average
// - functions 101 and 110 store rising and falling dimming targets
// - targets are step positions on the peak step scale
// - function 111 sets step time in 8 ms units and starts dimming
// - led current scales as reference times 2400 over 31 minus step
// - step zero turns current off; steps 30 and 31 are equal
// - converter stops above upper sense, restarts below lower sense
// - duty zero is off, all ones fully on, between is proportional
// - dimming walks one step per step time to the target
// - without dimming, new levels apply at the command acknowledge
// - rising past target wraps through max and zero; falling mirrors
`timescale 1ns/1ps
module rgd_led_ctrl #(
  parameter int STEP_LSB_CYCLES = rgd_pkg::STEP_LSB_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       ovp_above_i,
  input  wire logic       ovp_below_i,
  output logic [4:0]      led_step_o,
  output logic            mirror_en_o,
  output logic [4:0]      duty_channel_one_o,
  output logic [4:0]      duty_channel_two_o,
  output logic [4:0]      duty_channel_three_o,
  output logic [2:0]      led_pwm_o,
  output logic            conv_en_o,
  output logic            dim_busy_o
);
  // link side outputs
  logic [7:0] rx_cmd_byte;
  logic       rx_cmd_tgl;

  // command crossing
  logic [2:0] tgl_sync_reg, tgl_sync_next;
  logic       cmd_stb;
  logic [2:0] cmd_func;
  logic [4:0] cmd_val;

  // stored controls
  logic       shut_reg,      shut_next;
  logic [4:0] step_reg,      step_next;
  logic [4:0] duty_reg [rgd_pkg::CHANNELS];
  logic [4:0] duty_next [rgd_pkg::CHANNELS];
  logic [4:0] rise_tgt_reg,  rise_tgt_next;
  logic [4:0] fall_tgt_reg,  fall_tgt_next;
  logic       dir_up_reg,    dir_up_next;
  logic [4:0] step_time_reg, step_time_next;

  // dimming sequencer
  logic       dim_run_reg,   dim_run_next;
  logic       run_up_reg,    run_up_next;
  logic [4:0] run_tgt_reg,   run_tgt_next;
  logic [31:0] timer_reg,    timer_next;
  logic [4:0] start_tgt;
  logic       start_up;

  // overvoltage
  logic [1:0] above_sync_reg, above_sync_next;
  logic [1:0] below_sync_reg, below_sync_next;
  logic       conv_off_reg,   conv_off_next;

  // pwm timebase
  logic [10:0] tick_cnt_reg, tick_cnt_next;
  logic        pwm_tick;
  logic        led_gate;

  // one step along the ring of positions, wrapping at both ends
  function automatic logic [4:0] ring_step(input logic [4:0] pos, input logic up);
    logic [4:0] res;
    res = up ? 5'(pos + 5'h01) : 5'(pos - 5'h01);
    return res;
  endfunction

  // cycles spent on each dimming step for a given time value
  function automatic logic [31:0] step_cycles(input logic [4:0] val);
    logic [31:0] res;
    res = 32'(val) * 32'(STEP_LSB_CYCLES);
    return res;
  endfunction

  rgd_i2c_rx u_rx (
    .link_clk_i (link_clk_i),
    .rst_i      (rst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_n_o (sda_oe_n_o),
    .cmd_byte_o (rx_cmd_byte),
    .cmd_tgl_o  (rx_cmd_tgl)
  );

  // toggle crossing; the byte is held stable by the link side
  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], rx_cmd_tgl};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_sync_reg <= 3'h0;
    end else if (ce_i) begin
      tgl_sync_reg <= tgl_sync_next;
    end
  end

  assign cmd_stb  = tgl_sync_reg[2] ^ tgl_sync_reg[1];
  assign cmd_func = rx_cmd_byte[7:5];
  assign cmd_val  = rx_cmd_byte[4:0];

  // dimming target and direction chosen by the last target written
  assign start_up  = dir_up_reg;
  assign start_tgt = dir_up_reg ? rise_tgt_reg : fall_tgt_reg;

  // command decode and stored controls
  always_comb begin
    shut_next      = shut_reg;
    rise_tgt_next  = rise_tgt_reg;
    fall_tgt_next  = fall_tgt_reg;
    dir_up_next    = dir_up_reg;
    step_time_next = step_time_reg;
    for (int i = 0; i < rgd_pkg::CHANNELS; i++) begin
      duty_next[i] = duty_reg[i];
    end
    if (cmd_stb) begin
      shut_next = (cmd_func == rgd_pkg::FN_SHUTDOWN);
      for (int i = 0; i < rgd_pkg::CHANNELS; i++) begin
        if (cmd_func == 3'(rgd_pkg::FN_DUTY_ONE + 3'(i))) begin
          duty_next[i] = cmd_val;
        end
      end
      if (cmd_func == rgd_pkg::FN_RISE_TARGET) begin
        rise_tgt_next = cmd_val;
        dir_up_next   = 1'b1;
      end else if (cmd_func == rgd_pkg::FN_FALL_TARGET) begin
        fall_tgt_next = cmd_val;
        dir_up_next   = 1'b0;
      end else if (cmd_func == rgd_pkg::FN_STEP_TIME_RUN) begin
        step_time_next = cmd_val;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shut_reg      <= 1'b1;
      rise_tgt_reg  <= rgd_pkg::RST_TARGET;
      fall_tgt_reg  <= rgd_pkg::RST_TARGET;
      dir_up_reg    <= 1'b1;
      step_time_reg <= rgd_pkg::RST_STEP_TIME;
      for (int i = 0; i < rgd_pkg::CHANNELS; i++) begin
        duty_reg[i] <= rgd_pkg::RST_DUTY;
      end
    end else if (ce_i) begin
      shut_reg      <= shut_next;
      rise_tgt_reg  <= rise_tgt_next;
      fall_tgt_reg  <= fall_tgt_next;
      dir_up_reg    <= dir_up_next;
      step_time_reg <= step_time_next;
      for (int i = 0; i < rgd_pkg::CHANNELS; i++) begin
        duty_reg[i] <= duty_next[i];
      end
    end
  end

  // peak step position and dimming sequencer
  always_comb begin
    step_next    = step_reg;
    dim_run_next = dim_run_reg;
    run_up_next  = run_up_reg;
    run_tgt_next = run_tgt_reg;
    timer_next   = timer_reg;
    if (cmd_stb && cmd_func == rgd_pkg::FN_SHUTDOWN) begin
      dim_run_next = 1'b0;
    end else if (cmd_stb && cmd_func == rgd_pkg::FN_PEAK_STEP) begin
      step_next    = cmd_val;
      dim_run_next = 1'b0;
    end else if (cmd_stb && cmd_func == rgd_pkg::FN_STEP_TIME_RUN) begin
      run_up_next  = start_up;
      run_tgt_next = start_tgt;
      timer_next   = step_cycles(cmd_val);
      dim_run_next = (start_tgt != step_reg);
    end else if (dim_run_reg) begin
      if (timer_reg == 32'h0) begin
        step_next  = ring_step(step_reg, run_up_reg);
        timer_next = step_cycles(step_time_reg);
        if (ring_step(step_reg, run_up_reg) == run_tgt_reg) begin
          dim_run_next = 1'b0;
        end
      end else begin
        timer_next = 32'(timer_reg - 32'h1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_reg    <= rgd_pkg::RST_STEP;
      dim_run_reg <= 1'b0;
      run_up_reg  <= 1'b1;
      run_tgt_reg <= rgd_pkg::RST_TARGET;
      timer_reg   <= 32'h0;
    end else if (ce_i) begin
      step_reg    <= step_next;
      dim_run_reg <= dim_run_next;
      run_up_reg  <= run_up_next;
      run_tgt_reg <= run_tgt_next;
      timer_reg   <= timer_next;
    end
  end

  // overvoltage sense with hysteresis, no latch
  always_comb begin
    above_sync_next = {above_sync_reg[0], ovp_above_i};
    below_sync_next = {below_sync_reg[0], ovp_below_i};
    conv_off_next   = conv_off_reg;
    if (above_sync_reg[1]) begin
      conv_off_next = 1'b1;
    end else if (below_sync_reg[1]) begin
      conv_off_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      above_sync_reg <= 2'h0;
      below_sync_reg <= 2'h0;
      conv_off_reg   <= 1'b0;
    end else if (ce_i) begin
      above_sync_reg <= above_sync_next;
      below_sync_reg <= below_sync_next;
      conv_off_reg   <= conv_off_next;
    end
  end

  // pwm timebase shared by the three channels
  always_comb begin
    tick_cnt_next = (tick_cnt_reg == rgd_pkg::PWM_TICK_LAST) ? 11'h000
                                                            : 11'(tick_cnt_reg + 11'h001);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 11'h000;
    end else if (ce_i) begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  assign pwm_tick = (tick_cnt_reg == rgd_pkg::PWM_TICK_LAST);
  assign led_gate = ~shut_reg && (step_reg != 5'h00);

  for (genvar g = 0; g < rgd_pkg::CHANNELS; g++) begin : g_chan
    rgd_pwm_chan #(
      .W (rgd_pkg::VAL_W)
    ) u_pwm (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .tick_i    (pwm_tick),
      .duty_i    (duty_reg[g]),
      .gate_i    (led_gate),
      .pwm_o     (led_pwm_o[g])
    );
  end

  // mirror ratio 2400/(31-n) is set by the analog mirrors from this code
  assign led_step_o           = step_reg;
  assign mirror_en_o          = led_gate;
  assign duty_channel_one_o   = duty_reg[0];
  assign duty_channel_two_o   = duty_reg[1];
  assign duty_channel_three_o = duty_reg[2];
  assign conv_en_o            = ~shut_reg & ~conv_off_reg;
  assign dim_busy_o           = dim_run_reg;
endmodule

// ==== bench/rgd_led_ctrl_asserts.sv ====
// port level checks for the led command decoder
`timescale 1ns/1ps
module rgd_led_ctrl_asserts #(
  parameter int STEP_LSB_CYCLES = 4
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       link_clk_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       ovp_above_i,
  input wire logic       ovp_below_i,
  input wire logic [4:0] led_step_o,
  input wire logic       mirror_en_o,
  input wire logic [4:0] duty_channel_one_o,
  input wire logic [4:0] duty_channel_two_o,
  input wire logic [4:0] duty_channel_three_o,
  input wire logic [2:0] led_pwm_o,
  input wire logic       conv_en_o,
  input wire logic       dim_busy_o
);
  sequence s_trip;
    ovp_above_i [*3];
  endsequence
  sequence s_calm;
    (!ovp_above_i && !ovp_below_i) [*6];
  endsequence
  sequence s_walk;
    dim_busy_o && $past(dim_busy_o) && $changed(led_step_o);
  endsequence
  property p_ovp_hold;
    @(posedge ref_clk_i) disable iff (rst_i) s_trip ##1 s_calm |-> !conv_en_o;
  endproperty
  property p_ovp_trip;
    @(posedge ref_clk_i) disable iff (rst_i) ovp_above_i [*5] |-> !conv_en_o;
  endproperty
  property p_ovp_resume;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mirror_en_o && ovp_below_i && !ovp_above_i) [*5] |-> conv_en_o;
  endproperty
  property p_dim_step;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_walk |-> 5'(led_step_o - $past(led_step_o)) inside {5'h01, 5'h1F};
  endproperty
  property p_step_zero;
    @(posedge ref_clk_i) disable iff (rst_i) (led_step_o == 5'h00) [*2] |-> !mirror_en_o;
  endproperty
  property p_pwm_off;
    @(posedge ref_clk_i) disable iff (rst_i) (!mirror_en_o) [*3] |-> led_pwm_o == 3'h0;
  endproperty
  property p_full_on;
    @(posedge ref_clk_i) disable iff (rst_i)
      (mirror_en_o && duty_channel_two_o == 5'h1F) [*3] |-> led_pwm_o[1];
  endproperty
  property p_zero_off;
    @(posedge ref_clk_i) disable iff (rst_i)
      (duty_channel_three_o == 5'h00) [*3] |-> !led_pwm_o[2];
  endproperty
  property p_ack_edge;
    @(posedge link_clk_i) disable iff (rst_i) $changed(sda_oe_n_o) |-> !scl_i;
  endproperty
  property p_ack_hold;
    @(posedge link_clk_i) disable iff (rst_i)
      (!sda_oe_n_o && $rose(scl_i)) |=> (!sda_oe_n_o) [*8];
  endproperty
  a_ovp_hold: assert property (p_ovp_hold)
    else $error("converter resumed between thresholds");
  a_ovp_trip: assert property (p_ovp_trip)
    else $error("converter runs during overvoltage");
  a_ovp_resume: assert property (p_ovp_resume)
    else $error("converter did not restart");
  a_dim_step: assert property (p_dim_step)
    else $error("dimming moved by other than one step");
  a_step_zero: assert property (p_step_zero)
    else $error("mirrors enabled at step zero");
  a_pwm_off: assert property (p_pwm_off)
    else $error("channel on while current off");
  a_full_on: assert property (p_full_on)
    else $error("full duty channel not on");
  a_zero_off: assert property (p_zero_off)
    else $error("zero duty channel not off");
  a_ack_edge: assert property (p_ack_edge)
    else $error("data line moved while clock high");
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped during clock high");
endmodule

bind rgd_led_ctrl rgd_led_ctrl_asserts #(.STEP_LSB_CYCLES(STEP_LSB_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .ovp_above_i(ovp_above_i), .ovp_below_i(ovp_below_i), .led_step_o(led_step_o),
  .mirror_en_o(mirror_en_o), .duty_channel_one_o(duty_channel_one_o),
  .duty_channel_two_o(duty_channel_two_o), .duty_channel_three_o(duty_channel_three_o),
  .led_pwm_o(led_pwm_o), .conv_en_o(conv_en_o), .dim_busy_o(dim_busy_o)
);

// ==== bench/rgd_i2c_master.sv ====
// bus master model sending write frames
`timescale 1ns/1ps
module rgd_i2c_master #(
  parameter int Q = 63
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // quarter bit, four per bit keeps the clock under 400 kHz
  task automatic wq();
    repeat (Q) @(posedge clk_i);
  endtask
  // msb first, ack sampled with clock high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i];
      wq();
      scl_o <= 1'b1;
      wq();
      wq();
      scl_o <= 1'b0;
      wq();
    end
    sda_o <= 1'b1;
    wq();
    scl_o <= 1'b1;
    wq();
    ack = ~sda_i;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask
  // start, address byte, one command byte, stop
  task automatic frame(input logic [7:0] a, input logic [7:0] c, output logic [1:0] ack);
    sda_o <= 1'b0;
    wq();
    scl_o <= 1'b0;
    wq();
    put_byte(a, ack[1]);
    put_byte(c, ack[0]);
    sda_o <= 1'b0;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_o <= 1'b1;
    wq();
  endtask
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the led command decoder
`timescale 1ns/1ps
module tb;
  logic       ref_clk_i   = 1'b0;
  logic       link_clk    = 1'b0;
  logic       rst_i       = 1'b1;
  logic       ce_i        = 1'b1;
  logic       ovp_above_i = 1'b0;
  logic       ovp_below_i = 1'b1;
  logic       scl;
  logic       m_sda;
  wire logic  sda_w;
  logic       sda_o;
  logic       sda_oe_n_o;
  logic [4:0] led_step_o;
  logic [4:0] d1;
  logic [4:0] d2;
  logic [4:0] d3;
  logic [2:0] led_pwm_o;
  logic       mirror_en_o;
  logic       conv_en_o;
  logic       dim_busy_o;
  logic       seen_busy;
  logic       seen_lo;
  logic       seen_hi;
  int         failures   = 0;
  int         num_checks = 0;
  // command, then expected step and three duties
  localparam logic [27:0] ROWS [6] = '{
    {8'h3F, 5'h1F, 5'h00, 5'h00, 5'h00},
    {8'h45, 5'h1F, 5'h05, 5'h00, 5'h00},
    {8'h7F, 5'h1F, 5'h05, 5'h1F, 5'h00},
    {8'h9E, 5'h1F, 5'h05, 5'h1F, 5'h1E},
    {8'h80, 5'h1F, 5'h05, 5'h1F, 5'h00},
    {8'h2A, 5'h0A, 5'h05, 5'h1F, 5'h00}
  };

  always #5 ref_clk_i = ~ref_clk_i;
  initial begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end
  // pull-up on data, low when either side pulls
  assign sda_w = m_sda & (sda_oe_n_o | sda_o);

  rgd_i2c_master u_mst (.clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

  rgd_led_ctrl #(.STEP_LSB_CYCLES(4)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .ovp_above_i(ovp_above_i), .ovp_below_i(ovp_below_i), .led_step_o(led_step_o),
    .mirror_en_o(mirror_en_o), .duty_channel_one_o(d1), .duty_channel_two_o(d2),
    .duty_channel_three_o(d3), .led_pwm_o(led_pwm_o), .conv_en_o(conv_en_o),
    .dim_busy_o(dim_busy_o)
  );

  // positions visited while dimming
  always @(posedge ref_clk_i) begin
    if (dim_busy_o === 1'b1) begin
      seen_busy <= 1'b1;
      if (led_step_o === 5'h00) seen_lo <= 1'b1;
      if (led_step_o === 5'h1F) seen_hi <= 1'b1;
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] a, input logic [7:0] c, input logic [1:0] ae);
    logic [1:0] ack;
    u_mst.frame(a, c, ack);
    chk({3'h0, ack}, {3'h0, ae}, "ack");
  endtask
  task automatic regs(input logic [19:0] e);
    chk(led_step_o, e[19:15], "step");
    chk(d1, e[14:10], "duty one");
    chk(d2, e[9:5], "duty two");
    chk(d3, e[4:0], "duty three");
  endtask
  task automatic flags(input logic [2:0] e);
    chk({2'h0, mirror_en_o, conv_en_o, dim_busy_o}, {2'h0, e}, "flags");
  endtask
  task automatic chk_rst();
    regs(20'h00000);
    flags(3'h0);
    chk({1'b0, sda_oe_n_o, led_pwm_o}, 5'h08, "idle outputs");
    $display("test reset done");
  endtask
  task automatic dim(input logic [7:0] tg, input logic [7:0] tm, input logic [4:0] fin,
                     input logic [1:0] wrap);
    send(8'h70, tg, 2'h3);
    @(posedge ref_clk_i);
    {seen_busy, seen_lo, seen_hi} <= 3'h0;
    send(8'h70, tm, 2'h3);
    for (int k = 0; k < 2000 && dim_busy_o !== 1'b0; k++) wt(1);
    chk(led_step_o, fin, "dim end");
    chk({3'h0, seen_busy, 1'b0}, 5'h02, "dim ran");
    chk({3'h0, seen_lo, seen_hi}, {3'h0, wrap}, "dim wrap");
    $display("test dimming done");
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    {seen_busy, seen_lo, seen_hi} = 3'h0;
    wt(16);
    rst_i <= 1'b0;
    wt(8);
    chk_rst();
    for (int i = 0; i < 6; i++) begin
      send(8'h70, ROWS[i][27:20], 2'h3);
      regs(ROWS[i][19:0]);
    end
    flags(3'h6);
    chk({3'h0, led_pwm_o[2:1]}, 5'h01, "pwm");
    $display("test table done");
    send(8'h72, 8'h25, 2'h0);
    send(8'h71, 8'h3C, 2'h0);
    regs(ROWS[5][19:0]);
    $display("test foreign frames done");
    dim(8'hAF, 8'hE1, 5'h0F, 2'h0);
    dim(8'hA3, 8'hE0, 5'h03, 2'h3);
    dim(8'hC5, 8'hE0, 5'h05, 2'h3);
    ovp_below_i <= 1'b0;
    ovp_above_i <= 1'b1;
    wt(8);
    flags(3'h4);
    ovp_above_i <= 1'b0;
    wt(8);
    flags(3'h4);
    ovp_below_i <= 1'b1;
    wt(8);
    flags(3'h6);
    $display("test overvoltage done");
    ce_i <= 1'b0;
    send(8'h70, 8'h33, 2'h3);
    regs(20'h297E0);
    ce_i <= 1'b1;
    wt(8);
    regs(20'h997E0);
    $display("test clock enable done");
    send(8'h70, 8'h1F, 2'h3);
    wt(4);
    flags(3'h0);
    chk({2'h0, led_pwm_o}, 5'h00, "pwm off");
    $display("test shutdown done");
    rst_i <= 1'b1;
    wt(4);
    rst_i <= 1'b0;
    wt(8);
    chk_rst();
    give_verdict();
  end

  initial begin
    wt(90000);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
